//--- probe_pkg.sv
// Shared types and constants for the emulator probe signal logic.
// Assumes one 250 MHz clock and target bus pins that are asynchronous to it.
package probe_pkg;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 4;
    localparam int EVT_MIN_NS = 250;
    // Least time: round up to whole cycles
    localparam int EVT_MIN_CYC =
        (EVT_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Target-side setup of the map select before its strobe, informative only
    localparam int MAP_SETUP_NS = 125;
    localparam int CNT_W = 7;
    localparam logic [CNT_W-1:0] EVT_MIN_CNT = CNT_W'(EVT_MIN_CYC);

    // ------------------------------------------------------------------
    // Widths and reset values
    // ------------------------------------------------------------------
    localparam int ADDR_W = 16;
    localparam int SYNC_STAGES = 3;
    localparam logic TRIG_N_RST = 1'b1;
    localparam logic QUAL_RST = 1'b0;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic {
        RUN_STOPPED = 1'b0,
        RUN_RUNNING = 1'b1
    } run_state_t;

    // Target bus pins as seen at the probe
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic rd_n;
        logic wr_n;
        logic map_select_input_n;
    } bus_pins_t;

    localparam int BUS_W = $bits(bus_pins_t);

    // Event point: a set care bit means the address bit must match
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [ADDR_W-1:0] addr_care;
        logic on_read;
        logic on_write;
    } event_cfg_t;

    function automatic logic ev_match(input event_cfg_t cfg,
                                      input bus_pins_t bus);
        logic addr_ok;
        logic kind_ok;
        addr_ok = ((cfg.addr ^ bus.addr) & cfg.addr_care) == '0;
        kind_ok = (cfg.on_read & ~bus.rd_n) | (cfg.on_write & ~bus.wr_n);
        return addr_ok & kind_ok;
    endfunction : ev_match

endpackage : probe_pkg

//--- pin_sync.sv
// Three-stage pin synchroniser with agreement filter.
// Assumes inputs are asynchronous to clk; output moves only when the
// second and third stages agree.
`timescale 1ns/1ps
module pin_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [WIDTH-1:0] pin,
    output logic [WIDTH-1:0] value
);

    typedef struct packed {
        logic [WIDTH-1:0] s1;
        logic [WIDTH-1:0] s2;
        logic [WIDTH-1:0] s3;
        logic [WIDTH-1:0] val;
    } sync_t;

    localparam sync_t SYNC_RST = '{s1: RST_VAL, s2: RST_VAL, s3: RST_VAL,
                                   val: RST_VAL};

    sync_t q;
    sync_t d;

    always_comb begin
        d = q;
        d.s1 = pin;
        d.s2 = q.s1;
        d.s3 = q.s2;
        // Per bit, so a bus that settles unevenly still resolves
        for (int i = 0; i < WIDTH; i++) begin
            if (q.s2[i] == q.s3[i]) begin
                d.val[i] = q.s3[i];
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            q <= SYNC_RST;
        end else begin
            q <= d;
        end
    end

    assign value = q.val;

endmodule : pin_sync

//--- emulator_probe_signals.sv
// Probe signals of an in-circuit emulator: event trigger, emulation
// qualify and map select steering of memory accesses.
// Assumes bus pins arrive asynchronously; run and break pulses and the
// event configuration come from logic on clk.
//
// Functional notes
// [RULE1] Event trigger pulses low when a bus cycle meets the event point.
// [RULE2] Low from matching strobe rise to next strobe rise, at least 250 ns.
// [RULE3] With all event conditions don't-care, every bus cycle pulses.
// [RULE4] Emulation qualify is high from a run command until a breakpoint.
// [RULE5] In user mode an asserted map select sends all 64K to user memory.
// [RULE6] While stopped at a break map select is ignored, mapping is normal.
// [RULE7] Target drives map select low at least 125 ns before its strobe.
// [RULE8] Emulator program memory goes to user memory when map select is on.
// [RULE9] Emulation qualify is low when not running, after reset, at a break.
// [RULE10] Event trigger stays high while no matching event is in progress.
`timescale 1ns/1ps
module emulator_probe_signals
    import probe_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire bus_pins_t bus_pins,
    input wire event_cfg_t event_cfg,
    input wire logic run_cmd,
    input wire logic break_hit,
    input wire logic in_circuit_user_mode,
    input wire logic normal_map_user,
    output logic event_trigger_n,
    output logic emulation_qualify,
    output logic access_to_user_mem
);

    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    localparam bus_pins_t BUS_IDLE = '{addr: '0, rd_n: 1'b1, wr_n: 1'b1,
                                       map_select_input_n: 1'b1};

    bus_pins_t bus_s;

    pin_sync #(
        .WIDTH(BUS_W),
        .RST_VAL(BUS_IDLE)
    ) u_bus_sync (
        .clk(clk),
        .rst_n(rst_n),
        .pin(bus_pins),
        .value(bus_s)
    );

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        run_state_t run;
        logic qual;
        logic strobe;
        logic match;
        logic end_pend;
        logic trig_n;
        logic [CNT_W-1:0] cnt;
        logic user;
    } state_t;

    localparam state_t ST_RST = '{run: RUN_STOPPED, qual: QUAL_RST,
                                  strobe: 1'b0, match: 1'b0,
                                  end_pend: 1'b0, trig_n: TRIG_N_RST,
                                  cnt: '0, user: 1'b0};

    state_t q;
    state_t d;
    logic strobe_act;
    logic strobe_rise;

    always_comb begin
        d = q;
        strobe_act = ~bus_s.rd_n | ~bus_s.wr_n;
        strobe_rise = q.strobe & ~strobe_act;
        d.strobe = strobe_act;

        // Remember a hit anywhere inside the active strobe
        if (strobe_act && ev_match(event_cfg, bus_s)) begin
            d.match = 1'b1; // [RULE1] [RULE3]
        end

        if (q.cnt != '0) begin
            d.cnt = q.cnt - CNT_W'(1);
        end

        if (strobe_rise) begin
            d.match = 1'b0;
            if (q.match) begin
                // A back-to-back match simply extends the low pulse
                d.trig_n = 1'b0; // [RULE1] [RULE2]
                d.cnt = EVT_MIN_CNT; // [RULE2]
                d.end_pend = 1'b0;
            end else if (!q.trig_n) begin
                d.end_pend = 1'b1; // [RULE2]
            end
        end

        // A short bus cycle cannot cut the pulse below its minimum
        if (d.end_pend && d.cnt == '0) begin
            d.trig_n = 1'b1; // [RULE2] [RULE10]
            d.end_pend = 1'b0;
        end

        // Break wins over a run command in the same cycle
        if (break_hit) begin
            d.run = RUN_STOPPED; // [RULE9]
        end else if (run_cmd) begin
            d.run = RUN_RUNNING; // [RULE4]
        end
        d.qual = (d.run == RUN_RUNNING); // [RULE4] [RULE9]

        // Map select counts only while running; the target meets its
        // setup before the strobe, so the synced level is settled [RULE7]
        if (q.run == RUN_RUNNING && in_circuit_user_mode &&
                !bus_s.map_select_input_n) begin
            d.user = 1'b1; // [RULE5] [RULE8]
        end else begin
            d.user = normal_map_user; // [RULE6] [RULE8]
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            q <= ST_RST;
        end else begin
            q <= d;
        end
    end

    assign event_trigger_n = q.trig_n;
    assign emulation_qualify = q.qual;
    assign access_to_user_mem = q.user;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    // Cycles since the trigger was last started or reloaded
    logic [CNT_W:0] age_q;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            age_q <= '0;
        end else if (strobe_rise && q.match) begin
            age_q <= '0;
        end else if (age_q != '1) begin
            age_q <= age_q + (CNT_W+1)'(1);
        end
    end

    // Length of the current low pulse, saturating
    logic [CNT_W:0] low_len_q;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            low_len_q <= '0;
        end else if (q.trig_n) begin
            low_len_q <= '0;
        end else if (low_len_q != '1) begin
            low_len_q <= low_len_q + (CNT_W+1)'(1);
        end
    end

    AST_TRIG_START: assert property ( // [RULE1]
        strobe_rise && q.match |=> !event_trigger_n)
        else $error("trigger did not fall after matching strobe");
    AST_TRIG_MIN: assert property ( // [RULE2]
        $rose(event_trigger_n) |-> low_len_q >= {1'b0, EVT_MIN_CNT})
        else $error("trigger low pulse shorter than minimum");
    AST_TRIG_HOLD: assert property ( // [RULE2]
        $fell(event_trigger_n) |-> !event_trigger_n [*8])
        else $error("trigger low pulse ended early");
    AST_DONT_CARE: assert property ( // [RULE3]
        event_cfg.addr_care == '0 && event_cfg.on_read && event_cfg.on_write
        && strobe_act ##1 strobe_rise |=> !event_trigger_n)
        else $error("don't-care event gave no pulse");
    AST_QUAL_RUN: assert property ( // [RULE4]
        run_cmd && !break_hit |=> emulation_qualify)
        else $error("qualify not high after run");
    AST_QUAL_BRK: assert property ( // [RULE9]
        break_hit |=> !emulation_qualify)
        else $error("qualify high after break");
    AST_MAP_USER: assert property ( // [RULE5]
        q.run == RUN_RUNNING && in_circuit_user_mode
        && !bus_s.map_select_input_n |=> access_to_user_mem)
        else $error("map select did not route to user memory");
    AST_MAP_IGNORED: assert property ( // [RULE6]
        q.run == RUN_STOPPED |=> access_to_user_mem == $past(normal_map_user))
        else $error("map select honoured during break");
    AST_TRIG_IDLE: assert property ( // [RULE10]
        event_trigger_n && !(strobe_rise && q.match) |=> event_trigger_n)
        else $error("trigger fell without a match");
    AST_TRIG_END: assert property ( // [RULE2]
        strobe_rise && !q.match && !event_trigger_n
        && age_q >= {1'b0, EVT_MIN_CNT} |=> event_trigger_n)
        else $error("trigger did not end at next strobe");
    AST_TRIG_WAIT: assert property ( // [RULE2]
        !event_trigger_n && !q.end_pend && !strobe_rise |=> !event_trigger_n)
        else $error("trigger ended without a strobe");
    AST_QUAL_HOLD: assert property ( // [RULE4] [RULE9]
        !run_cmd && !break_hit |=> $stable(emulation_qualify))
        else $error("qualify moved without run or break");
    AST_MAP_NORMAL: assert property ( // [RULE8]
        !in_circuit_user_mode
        |=> access_to_user_mem == $past(normal_map_user))
        else $error("map select honoured outside user mode");

    COV_PULSE: cover property ($fell(event_trigger_n) ##[1:300]
        $rose(event_trigger_n));
    COV_RUN_BREAK: cover property ($rose(emulation_qualify) ##[1:100]
        $fell(emulation_qualify));
    COV_MAP: cover property (q.run == RUN_RUNNING
        && !bus_s.map_select_input_n ##1 access_to_user_mem);
    COV_STRETCH: cover property (strobe_rise && !q.match
        && !event_trigger_n && q.cnt != '0);
    COV_DONT_CARE: cover property (event_cfg.addr_care == '0
        && strobe_rise && q.match);

endmodule : emulator_probe_signals

//--- target_bus_model.sv
// Target bus model: drives the address, strobes and map select pins.
// Assumes the bench calls its tasks; pins change at falling edges.
`timescale 1ns/1ps
module target_bus_model
    import probe_pkg::*;
(
    input wire logic clk,
    output bus_pins_t bus_pins
);
    initial bus_pins = {16'h0000, 3'b111};

    // Released address lines show the inverse of the last value
    task automatic cycle(input logic [ADDR_W-1:0] a, input logic wr);
        @(negedge clk) bus_pins.addr = a;
        repeat (2) @(negedge clk);
        bus_pins.rd_n = wr;
        bus_pins.wr_n = ~wr;
        repeat (8) @(negedge clk);
        bus_pins.rd_n = 1'b1;
        bus_pins.wr_n = 1'b1;
        @(negedge clk) bus_pins.addr = ~a;
    endtask : cycle

    task automatic map(input logic v);
        @(negedge clk) bus_pins.map_select_input_n = v;
        // Settled well ahead of any later strobe
        repeat (32) @(negedge clk);
    endtask : map
endmodule : target_bus_model

//--- tb.sv
// Bench for the probe signals: event trigger, qualify and map steering.
// Assumes the partner model drives the target bus pins.
`timescale 1ns/1ps
`define CHK(g, e) \
    begin \
        checks_done++; \
        if ((g) !== (e)) begin \
            error_cnt++; \
            $display("[ERR] %0t got %h exp %h", $time, g, e); \
        end \
    end
module tb
    import probe_pkg::*;
;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    bus_pins_t pins;
    event_cfg_t cfg = '0;
    logic run_cmd = 1'b0;
    logic break_hit = 1'b0;
    logic user_mode = 1'b0;
    logic norm_user = 1'b0;
    logic trig_n;
    logic qual;
    logic to_user;
    int error_cnt = 0;
    int checks_done = 0;
    int cyc = 0;
    int low_cnt = 0;
    int pulse_len = 0;
    int n;

    always #2 clk = ~clk;
    target_bus_model bus (.clk(clk), .bus_pins(pins));
    emulator_probe_signals dut (.clk(clk), .rst_n(rst_n), .bus_pins(pins),
        .event_cfg(cfg), .run_cmd(run_cmd), .break_hit(break_hit),
        .in_circuit_user_mode(user_mode), .normal_map_user(norm_user),
        .event_trigger_n(trig_n), .emulation_qualify(qual),
        .access_to_user_mem(to_user));

    // Low time of the trigger, in clock cycles, for the latest pulse
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (trig_n === 1'b0) begin
            low_cnt <= low_cnt + 1;
        end else if (low_cnt != 0) begin
            pulse_len <= low_cnt;
            low_cnt <= 0;
        end
        if (cyc == 6000) begin
            error_cnt++;
            print_verdict();
        end
    end

    task automatic print_verdict();
        $display("checks %0d errors %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : print_verdict

    task automatic wait_trig(input logic v);
        n = 0;
        while (trig_n !== v && n < 200) begin
            @(negedge clk);
            n++;
        end
    endtask : wait_trig

    task automatic pulse(input logic r, input logic b);
        @(negedge clk);
        run_cmd = r;
        break_hit = b;
        @(negedge clk);
        run_cmd = 1'b0;
        break_hit = 1'b0;
    endtask : pulse

    task automatic test_run();
        pulse(1'b1, 1'b0);
        `CHK(qual, 1'b1)
        repeat (5) @(negedge clk);
        `CHK(qual, 1'b1)
        pulse(1'b1, 1'b1);
        `CHK(qual, 1'b0)
        pulse(1'b1, 1'b0);
        pulse(1'b0, 1'b1);
        `CHK(qual, 1'b0)
        $display("test run done");
    endtask : test_run

    task automatic test_map();
        user_mode = 1'b1;
        bus.map(1'b0);
        `CHK(to_user, 1'b0)
        norm_user = 1'b1;
        repeat (2) @(negedge clk);
        `CHK(to_user, 1'b1)
        norm_user = 1'b0;
        pulse(1'b1, 1'b0);
        repeat (2) @(negedge clk);
        `CHK(to_user, 1'b1)
        user_mode = 1'b0;
        repeat (2) @(negedge clk);
        `CHK(to_user, 1'b0)
        user_mode = 1'b1;
        bus.map(1'b1);
        `CHK(to_user, 1'b0)
        norm_user = 1'b1;
        repeat (2) @(negedge clk);
        `CHK(to_user, 1'b1)
        norm_user = 1'b0;
        pulse(1'b0, 1'b1);
        $display("test map done");
    endtask : test_map

    task automatic test_evt();
        cfg = {16'h1234, 16'hffff, 2'b10};
        bus.cycle(16'h0234, 1'b0);
        bus.cycle(16'h1234, 1'b1);
        repeat (8) @(negedge clk);
        `CHK(trig_n, 1'b1)
        bus.cycle(16'h1234, 1'b0);
        wait_trig(1'b0);
        `CHK(n <= 8, 1'b1)
        repeat (100) @(negedge clk);
        `CHK(trig_n, 1'b0)
        bus.cycle(16'h1235, 1'b0);
        wait_trig(1'b1);
        `CHK(n <= 8, 1'b1)
        bus.cycle(16'h1234, 1'b0);
        wait_trig(1'b0);
        bus.cycle(16'h1235, 1'b0);
        repeat (8) @(negedge clk);
        `CHK(trig_n, 1'b0)
        wait_trig(1'b1);
        @(negedge clk);
        `CHK(pulse_len >= EVT_MIN_CYC, 1'b1)
        `CHK(pulse_len <= EVT_MIN_CYC + 3, 1'b1)
        $display("test event done");
    endtask : test_evt

    task automatic test_dc();
        cfg = '0;
        cfg.on_read = 1'b1;
        cfg.on_write = 1'b1;
        bus.cycle(16'habcd, 1'b1);
        wait_trig(1'b0);
        `CHK(n <= 8, 1'b1)
        repeat (70) @(negedge clk);
        bus.cycle(16'h4321, 1'b0);
        repeat (8) @(negedge clk);
        `CHK(trig_n, 1'b0)
        cfg = {16'h1234, 16'hffff, 2'b10};
        repeat (70) @(negedge clk);
        bus.cycle(16'h0000, 1'b0);
        wait_trig(1'b1);
        `CHK(trig_n, 1'b1)
        $display("test dont care done");
    endtask : test_dc

    task automatic test_rst();
        cfg = '0;
        cfg.on_read = 1'b1;
        cfg.on_write = 1'b1;
        pulse(1'b1, 1'b0);
        bus.cycle(16'h5a5a, 1'b1);
        wait_trig(1'b0);
        `CHK(trig_n, 1'b0)
        `CHK(qual, 1'b1)
        rst_n = 1'b0;
        @(negedge clk);
        `CHK(trig_n, 1'b1)
        `CHK(qual, 1'b0)
        `CHK(to_user, 1'b0)
        rst_n = 1'b1;
        repeat (2) @(negedge clk);
        `CHK(trig_n, 1'b1)
        `CHK(qual, 1'b0)
        $display("test reset done");
    endtask : test_rst

    initial begin
        repeat (16) @(negedge clk);
        `CHK(trig_n, 1'b1)
        `CHK(qual, 1'b0)
        `CHK(to_user, 1'b0)
        rst_n = 1'b1;
        repeat (8) @(negedge clk);
        test_run();
        test_map();
        test_evt();
        test_dc();
        test_rst();
        print_verdict();
    end
endmodule : tb
